// *** nv_mem_map.vh ***
`ifndef NV_MEM_MAP_VH
`define NV_MEM_MAP_VH

// ****************************************************************
// Geometry of the memory word array.
// ****************************************************************
`define ADDR_WIDTH 18
`define DATA_WIDTH 16
`define LANE_WIDTH 8

// ****************************************************************
// Timing figures in nanoseconds and the clock period.
// ****************************************************************
`define CLK_PERIOD_NS 25
`define STARTUP_NS 2000000
`define READ_CYCLE_NS 35
`define READ_ACCESS_NS 35
`define WRITE_PULSE_NS 20
`define WRITE_RECOVERY_NS 12

// Cycle counts, least times rounded up.
`define STARTUP_CYCLES ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLES ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYCLES ((`WRITE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// Controller state codes.
// ****************************************************************
`define ST_STARTUP 3'h0
`define ST_IDLE 3'h1
`define ST_READ 3'h2
`define ST_WRITE 3'h3
`define ST_RECOVER 3'h4

`endif

// *** nv_mem_host.v ***
// What this block does
// [RULE1] Memory holds 262144 sixteen-bit words, 18-bit index.
// [RULE2] Low byte on low lane, low select.
// [RULE3] High byte on high lane, high select.
// [RULE4] Chip-on high deselects device, lanes released.
// [RULE5] Both strobes or both selects high: idle.
// [RULE6] Read drives only lanes whose select low.
// [RULE7] Write updates only lanes whose select low.
// [RULE8] No refresh is ever needed.
// [RULE9] Device ignores writes below inhibit level.
// [RULE10] No access until 2 ms after power.
// [RULE11] Chip-on, store-strobe high during startup.
// [RULE12] Power-on reset holds them beyond startup.
// [RULE13] Brownout restarts the startup wait.
// [RULE14] Address and data stable across store overlap.
// [RULE15] Output-drive stays high during writes.
// [RULE16] Store-strobe held high throughout reads.
// [RULE17] Count cycles; release lanes before reading.

// The shared map must be seen before the parameter default uses it.
// It holds only defines, so it is safe to pull in at file level.
`include "nv_mem_map.vh"

module nv_mem_host #(
    parameter STARTUP_CYCLES = `STARTUP_CYCLES
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire supply_ok,
    input wire req_valid,
    input wire req_write,
    input wire [17:0] req_addr,
    input wire [15:0] req_wdata,
    input wire [1:0] req_byte_en,
    output reg req_ready,
    output reg rsp_valid,
    output reg [15:0] rsp_rdata,
    output reg mem_ready,
    output reg [17:0] word_addr,
    output reg chip_on_n,
    output reg store_strobe_n,
    output reg output_drive_n,
    output reg low_half_select_n,
    output reg high_half_select_n,
    input wire [7:0] low_data_lane_in,
    output reg [7:0] low_data_lane_out,
    output reg low_data_lane_oe,
    input wire [7:0] high_data_lane_in,
    output reg [7:0] high_data_lane_out,
    output reg high_data_lane_oe
);

    // ****************************************************************
    // Counters and state.
    // ****************************************************************

    // Current controller state.
    reg [2:0] state_reg;
    // Cycle counter for startup and each access phase.
    reg [23:0] count_reg;
    // Phase lengths as full 32-bit values, before they meet the counter.
    localparam [31:0] START_RAW = STARTUP_CYCLES;
    localparam [31:0] READ_RAW = `READ_CYCLES;
    localparam [31:0] WRITE_RAW = `WRITE_CYCLES;
    localparam [31:0] RECOVER_RAW = `RECOVER_CYCLES;

    // Phase lengths cut to the counter width; every default fits in 24 bits.
    localparam [23:0] START_LEN = START_RAW[23:0];
    localparam [23:0] READ_LEN = READ_RAW[23:0];
    localparam [23:0] WRITE_LEN = WRITE_RAW[23:0];
    localparam [23:0] RECOVER_LEN = RECOVER_RAW[23:0];

    // ****************************************************************
    // Main sequencer.
    // ****************************************************************

    // The sequencer runs every access from counted phases.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Power-on reset parks every strobe high and releases the lanes.
            state_reg <= `ST_STARTUP;
            count_reg <= 24'h000000;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            mem_ready <= 1'b0;
            word_addr <= 18'h00000;
            chip_on_n <= 1'b1; // [RULE12]
            store_strobe_n <= 1'b1; // [RULE12]
            output_drive_n <= 1'b1;
            low_half_select_n <= 1'b1;
            high_half_select_n <= 1'b1;
            low_data_lane_out <= 8'h00;
            low_data_lane_oe <= 1'b0;
            high_data_lane_out <= 8'h00;
            high_data_lane_oe <= 1'b0;
        end else begin
            // The answer strobe and the ready flag are single-cycle by default.
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            if (!supply_ok) begin
                // Supply lost: park the pins and restart the wait.
                // A write cut short here cannot land, since the device takes no store while supply_ok is low.
                state_reg <= `ST_STARTUP; // [RULE13]
                count_reg <= 24'h000000;
                mem_ready <= 1'b0;
                chip_on_n <= 1'b1; // [RULE4]
                store_strobe_n <= 1'b1; // [RULE9]
                output_drive_n <= 1'b1;
                low_half_select_n <= 1'b1;
                high_half_select_n <= 1'b1;
                low_data_lane_oe <= 1'b0;
                high_data_lane_oe <= 1'b0;
            end else begin
                // One phase per state; startup, read, write and recovery are timed by count_reg.
                case (state_reg)
                    `ST_STARTUP: begin
                        // Hold strobes high for the full startup interval.
                        chip_on_n <= 1'b1; // [RULE11]
                        store_strobe_n <= 1'b1; // [RULE11]
                        if (count_reg >= START_LEN) begin // [RULE10]
                            // Startup wait over: open for requests.
                            state_reg <= `ST_IDLE;
                            mem_ready <= 1'b1;
                            req_ready <= 1'b1;
                            count_reg <= 24'h000000;
                        end else begin
                            // Still inside the startup wait.
                            count_reg <= count_reg + 24'h000001;
                        end
                    end
                    `ST_IDLE: begin
                        // No refresh is scheduled; idle simply waits.
                        req_ready <= 1'b1; // [RULE8]
                        if (req_valid && req_ready) begin
                            // Request taken: put address and selects on the pins.
                            req_ready <= 1'b0;
                            word_addr <= req_addr; // [RULE1]
                            chip_on_n <= 1'b0;
                            low_half_select_n <= ~req_byte_en[0]; // [RULE2]
                            high_half_select_n <= ~req_byte_en[1]; // [RULE3]
                            count_reg <= 24'h000000;
                            if (req_write) begin
                                // Drive data only on selected lanes.
                                store_strobe_n <= 1'b0; // [RULE7]
                                output_drive_n <= 1'b1; // [RULE15]
                                low_data_lane_out <= req_wdata[7:0];
                                high_data_lane_out <= req_wdata[15:8];
                                low_data_lane_oe <= req_byte_en[0];
                                high_data_lane_oe <= req_byte_en[1];
                                state_reg <= `ST_WRITE;
                            end else begin
                                // Lanes are already released before drive.
                                store_strobe_n <= 1'b1; // [RULE16]
                                output_drive_n <= 1'b0; // [RULE17]
                                low_data_lane_oe <= 1'b0;
                                high_data_lane_oe <= 1'b0;
                                state_reg <= `ST_READ;
                            end
                        end
                    end
                    `ST_READ: begin
                        // Wait the access time then capture selected lanes.
                        if (count_reg + 24'h000001 >= READ_LEN) begin // [RULE6]
                            // Access time met: take the data, deselected bytes read as zero.
                            rsp_rdata <= {high_half_select_n ? 8'h00 : high_data_lane_in,
                                low_half_select_n ? 8'h00 : low_data_lane_in};
                            rsp_valid <= 1'b1;
                            chip_on_n <= 1'b1;
                            output_drive_n <= 1'b1;
                            low_half_select_n <= 1'b1; // [RULE5]
                            high_half_select_n <= 1'b1;
                            count_reg <= 24'h000000;
                            state_reg <= `ST_RECOVER;
                        end else begin
                            // Device outputs are still settling.
                            count_reg <= count_reg + 24'h000001;
                        end
                    end
                    `ST_WRITE: begin
                        // Address and data hold while the strobe is low.
                        if (count_reg + 24'h000001 >= WRITE_LEN) begin // [RULE14]
                            // Pulse long enough: strobes rise, data stays one cycle more.
                            store_strobe_n <= 1'b1;
                            chip_on_n <= 1'b1;
                            rsp_valid <= 1'b1;
                            count_reg <= 24'h000000;
                            state_reg <= `ST_RECOVER;
                        end else begin
                            // Write pulse still running.
                            count_reg <= count_reg + 24'h000001;
                        end
                    end
                    `ST_RECOVER: begin
                        // Data held past strobe rise, then lanes released.
                        low_data_lane_oe <= 1'b0;
                        high_data_lane_oe <= 1'b0;
                        low_half_select_n <= 1'b1;
                        high_half_select_n <= 1'b1;
                        // Ready returns only once the recovery time is counted.
                        if (count_reg + 24'h000001 >= RECOVER_LEN) begin // [RULE17]
                            state_reg <= `ST_IDLE;
                            req_ready <= 1'b1;
                            count_reg <= 24'h000000;
                        end else begin
                            // Recovery still running.
                            count_reg <= count_reg + 24'h000001;
                        end
                    end
                    default: begin
                        // Unknown code: restart cleanly.
                        // Only chip_on_n and store_strobe_n follow once the startup state parks them; mem_ready keeps its value.
                        state_reg <= `ST_STARTUP;
                        count_reg <= 24'h000000;
                    end
                endcase
            end
        end
    end

endmodule

// *** nv_mem_host_chk.sv ***
// ****
// Pin-level checks on the host controller.
// ****
module nv_mem_host_chk #(
    parameter STARTUP_CYCLES = 20
) (
    input wire ref_clk,
    input wire sys_rst,
    input wire supply_ok,
    input wire req_valid,
    input wire req_write,
    input wire req_ready,
    input wire [17:0] req_addr,
    input wire [1:0] req_byte_en,
    input wire rsp_valid,
    input wire mem_ready,
    input wire [17:0] word_addr,
    input wire chip_on_n,
    input wire store_strobe_n,
    input wire output_drive_n,
    input wire low_half_select_n,
    input wire high_half_select_n,
    input wire low_data_lane_oe,
    input wire high_data_lane_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Strobes stay high until the startup wait is over.
    AST_STARTUP_IDLE: assert property (!mem_ready |-> chip_on_n && store_strobe_n)
        else $error("access strobe low before startup done");
    AST_BROWNOUT: assert property (!supply_ok |=> !mem_ready && chip_on_n)
        else $error("access allowed after supply loss");
    AST_READ_NO_STORE: assert property (!output_drive_n |-> store_strobe_n)
        else $error("store strobe low in a read");
    AST_WRITE_NO_DRIVE: assert property (!store_strobe_n |-> output_drive_n)
        else $error("output drive low in a write");
    AST_RELEASE_LANES: assert property (!output_drive_n |-> !low_data_lane_oe && !high_data_lane_oe)
        else $error("host drives lanes while device outputs on");
    AST_STORE_DATA: assert property (!store_strobe_n |->
        (low_half_select_n || low_data_lane_oe) && (high_half_select_n || high_data_lane_oe))
        else $error("selected lane not driven in a store");
    // Address and byte selects follow the request that was taken.
    AST_TAKE_PINS: assert property (req_valid && req_ready |=> word_addr == $past(req_addr)
        && low_half_select_n == !$past(req_byte_en[0])
        && high_half_select_n == !$past(req_byte_en[1]))
        else $error("address or selects differ from request");
    AST_READ_TIME: assert property (req_valid && req_ready && !req_write |->
        ##1 (!chip_on_n && !output_drive_n)[*2] ##1 rsp_valid)
        else $error("read phase or answer mistimed");
    AST_WRITE_TIME: assert property (req_valid && req_ready && req_write |->
        ##1 (!chip_on_n && !store_strobe_n) ##1 (store_strobe_n && rsp_valid))
        else $error("write phase or answer mistimed");
endmodule

bind nv_mem_host nv_mem_host_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (.*);

// *** nv_mem_model.sv ***
// ****
// Behavioural word memory on the far side of the pins.
// ****
module nv_mem_model (
    input wire ref_clk,
    input wire supply_ok,
    input wire [17:0] word_addr,
    input wire chip_on_n,
    input wire store_strobe_n,
    input wire output_drive_n,
    input wire [1:0] sel_n,
    input wire [15:0] host_data,
    input wire [1:0] host_oe,
    output wire [15:0] bus_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:262143]; // Static array, never refreshed.
    logic [15:0] last = 16'h0; // Last wire level, inverted when nobody drives.
    logic rd;
    assign rd = !chip_on_n && !output_drive_n && store_strobe_n;
    assign bus_wire[7:0] = host_oe[0] ? host_data[7:0] :
        (rd && !sel_n[0]) ? mem[word_addr][7:0] : ~last[7:0];
    assign bus_wire[15:8] = host_oe[1] ? host_data[15:8] :
        (rd && !sel_n[1]) ? mem[word_addr][15:8] : ~last[15:8];
    // Stores happen only in the overlap and only with good supply.
    always @(posedge ref_clk) begin
        last <= bus_wire;
        if (!chip_on_n && !store_strobe_n && supply_ok) begin
            if (!sel_n[0]) mem[word_addr][7:0] <= bus_wire[7:0];
            if (!sel_n[1]) mem[word_addr][15:8] <= bus_wire[15:8];
        end
    end
endmodule

// *** tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SU = 20;
    logic ref_clk = 1'b0, sys_rst = 1'b1, supply_ok = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic [17:0] req_addr = 18'h0, word_addr, a;
    logic [15:0] req_wdata = 16'h0, rsp_rdata, bus_wire;
    logic [1:0] req_byte_en = 2'h0;
    logic req_ready, rsp_valid, mem_ready, chip_on_n, store_strobe_n, output_drive_n;
    logic low_half_select_n, high_half_select_n, low_data_lane_oe, high_data_lane_oe;
    logic [7:0] low_data_lane_out, high_data_lane_out;
    logic [15:0] shadow [0:15]; // Expected contents, indexed by the low address bits.
    logic [31:0] r;
    int num_errors = 0, samples_checked = 0, seed = 87355, n;
    nv_mem_host #(.STARTUP_CYCLES(SU)) uut (.low_data_lane_in(bus_wire[7:0]),
        .high_data_lane_in(bus_wire[15:8]), .*);
    nv_mem_model dev (.sel_n({high_half_select_n, low_half_select_n}),
        .host_data({high_data_lane_out, low_data_lane_out}),
        .host_oe({high_data_lane_oe, low_data_lane_oe}), .*);
    always #12.5 ref_clk = ~ref_clk;
    // ****
    // Shared helpers.
    // ****
    task automatic check(logic [17:0] seen, logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] exp_read(logic [17:0] ad, logic [1:0] be);
        return {be[1] ? shadow[ad[3:0]][15:8] : 8'h00, be[0] ? shadow[ad[3:0]][7:0] : 8'h00};
    endfunction
    // One request, held until taken, then the answer is awaited and judged.
    task automatic access(logic w, logic [17:0] ad, logic [15:0] d, logic [1:0] be);
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1 n++;
        end
        {req_valid, req_write, req_addr, req_wdata, req_byte_en} = {1'b1, w, ad, d, be};
        @(posedge ref_clk);
        #1 req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 9) begin
            @(posedge ref_clk);
            #1 n++;
        end
        check(18'(n), w ? 18'h1 : 18'h2);
        if (!w)
            check(rsp_rdata, exp_read(ad, be));
        else
            for (int i = 0; i < 2; i++) if (be[i]) shadow[ad[3:0]][i*8+:8] = d[i*8+:8];
    endtask
    task automatic wait_ready();
        n = 0;
        while (mem_ready !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1 n++;
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****
    // Main sequence.
    // ****
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 check({chip_on_n, store_strobe_n, low_data_lane_oe, req_ready}, 18'hc);
        sys_rst = 1'b0;
        wait_ready();
        check(18'(n), 18'(SU + 1));
        for (int i = 0; i < 9; i++) access(1'b1, i == 8 ? 18'h3ffff : 18'(i), 16'($random(seed)), 2'h3);
        for (int b = 0; b < 4; b++) begin
            access(1'b1, 18'h3ffff, 16'($random(seed)), 2'(b));
            access(1'b0, 18'h3ffff, 16'h0, 2'(b));
        end
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            a = r[3] ? 18'h3ffff : {15'h0, r[2:0]};
            access(r[4], a, r[31:16], r[6:5]);
        end
        supply_ok = 1'b0;
        @(posedge ref_clk);
        #1 check({mem_ready, req_ready, chip_on_n}, 18'h1);
        repeat (3) @(posedge ref_clk);
        #1 supply_ok = 1'b1;
        wait_ready();
        check(18'(n), 18'(SU + 1));
        for (int i = 0; i < 8; i++) access(1'b0, 18'(i), 16'h0, 2'h3);
        close_out();
    end
    initial begin
        #(25 * 20000);
        num_errors++;
        close_out();
    end
endmodule
